// ==== pkg/pin_irq_pkg.sv ====
// Purpose: Shared constants for the port pin interrupt unit
// Assumes: 32-bit APB data, registers in the low byte of each word
// Notes: Offsets are byte addresses
package pin_irq_pkg;

  localparam int PIN_COUNT = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_PORT_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT_DIRECTION = 8'h0c;
  localparam logic [7:0] OFS_PORT_PULLUP = 8'h10;
  localparam logic [7:0] OFS_BREAK_CONTROL = 8'h14;

  // Status and control field positions
  localparam int BIT_SENSITIVITY = 0;
  localparam int BIT_MASK = 1;
  localparam int BIT_ACK = 2;
  localparam int BIT_PENDING = 3;

  // Enable register: pins in 5:0, auto wakeup in 6
  localparam int BIT_AWU_ENABLE = 6;

  // Break control field position
  localparam int BIT_BREAK_CLEAR = 0;

  // Values after reset
  localparam logic RST_SENSITIVITY = 1'b0;
  localparam logic RST_MASK = 1'b0;
  localparam logic RST_BREAK_CLEAR = 1'b0;
  localparam logic [5:0] RST_ENABLE = 6'h00;
  localparam logic [5:0] RST_PORT = 6'h00;

  // Interrupt vector location, high byte then low byte
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hffe0;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hffe1;

  // Synchroniser depth in clock cycles
  localparam int SYNC_STAGES = 2;

endpackage

// ==== core/pin_sync.sv ====
// Purpose: Two flip-flop synchroniser for a vector of pin levels
// Assumes: Pins are asynchronous to clk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // Reset to high so an idle pulled-up pin is not seen as a fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '1;
      synced <= '1;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ==== core/port_a_pads.sv ====
// Purpose: Port A pad control with interrupt override of direction and pullup
// Assumes: Pin levels already synchronised
// Notes: Combinational; the caller registers read data
`timescale 1ns/1ps
`default_nettype none

module port_a_pads #(
  parameter int WIDTH = 6
) (
  input wire logic [WIDTH-1:0] irqEnable,
  input wire logic [WIDTH-1:0] direction,
  input wire logic [WIDTH-1:0] pullupEnable,
  input wire logic [WIDTH-1:0] dataOut,
  input wire logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] padOe,
  output logic [WIDTH-1:0] padPullup,
  output logic [WIDTH-1:0] readValue
);

  // An interrupt pin is always an input, whatever its direction bit
  assign padOe = direction & ~irqEnable;
  // Interrupt pins get a pullup regardless of the general pullup bit
  assign padPullup = irqEnable | (pullupEnable & ~padOe);
  // Pin level reads only through direction 0; else the output latch
  assign readValue = (pinLevel & ~direction) | (dataOut & direction);

endmodule // port_a_pads

`default_nettype wire

// ==== core/pin_irq_unit.sv ====
// Purpose: Six-pin port interrupt unit with APB register access
// Assumes: APB master on clk; CPU vector fetch and break state on clk
// Notes: Pins pass a two-stage synchroniser before any detection
`timescale 1ns/1ps
`default_nettype none

module pin_irq_unit
  import pin_irq_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port A pins
  input wire logic [PINS-1:0] padIn,
  output logic [PINS-1:0] padOut,
  output logic [PINS-1:0] padOe,
  output logic [PINS-1:0] padPullup,
  // CPU and system side
  input wire logic vectorFetch,
  input wire logic breakState,
  input wire logic awuWake,
  output logic irqRequest,
  output logic [15:0] irqVectorHi,
  output logic [15:0] irqVectorLo
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [1:0] {
    LVL_IDLE = 2'b00,
    LVL_HELD = 2'b01,
    LVL_ACKED = 2'b11
  } level_state_t;

  logic [PINS-1:0] pinEnable;
  logic awuEnable;
  logic sensitivity;
  logic irqMask;
  logic breakClearEnable;
  logic [PINS-1:0] portDirection;
  logic [PINS-1:0] portPullup;

  logic [PINS-1:0] pinLevel;
  logic [PINS-1:0] portRead;
  logic awuLatch;
  logic allHigh;
  logic prevAllHigh;
  logic fallSeen;
  logic requestLatch;
  level_state_t levelState;
  level_state_t next_levelState;

  logic writeCycle;
  logic setupRead;
  logic byte0;
  logic ackWrite;
  logic clearAllowed;
  logic ackEvent;
  logic awuClear;
  logic latchSet;
  logic latchClear;
  logic [31:0] next_prdata;
  logic next_pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True for any offset that holds a register
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == OFS_STATUS_CONTROL) || (addr == OFS_ENABLE) ||
                (addr == OFS_PORT_DATA) || (addr == OFS_PORT_DIRECTION) ||
                (addr == OFS_PORT_PULLUP) || (addr == OFS_BREAK_CONTROL);
  endfunction

  // Address match for one register; the byte lane is checked in writeCycle
  function automatic logic write_hit(input logic [7:0] addr, input logic [7:0] ofs);
    write_hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Every register lives in byte lane 0; other lanes are ignored
  assign byte0 = pstrb[0];
  assign writeCycle = psel && penable && pwrite && byte0 && is_mapped(paddr);
  assign setupRead = psel && !penable;
  // Zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign ackWrite = writeCycle && write_hit(paddr, OFS_STATUS_CONTROL) &&
                    pwdata[BIT_ACK];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sensitivity <= RST_SENSITIVITY;
      irqMask <= RST_MASK;
    end else if (writeCycle && write_hit(paddr, OFS_STATUS_CONTROL)) begin
      sensitivity <= pwdata[BIT_SENSITIVITY];
      irqMask <= pwdata[BIT_MASK];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinEnable <= RST_ENABLE;
      awuEnable <= 1'b0;
    end else if (writeCycle && write_hit(paddr, OFS_ENABLE)) begin
      pinEnable <= pwdata[PINS-1:0];
      awuEnable <= pwdata[BIT_AWU_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      padOut <= RST_PORT;
    end else if (writeCycle && write_hit(paddr, OFS_PORT_DATA)) begin
      padOut <= pwdata[PINS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portDirection <= RST_PORT;
    end else if (writeCycle && write_hit(paddr, OFS_PORT_DIRECTION)) begin
      portDirection <= pwdata[PINS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portPullup <= RST_PORT;
    end else if (writeCycle && write_hit(paddr, OFS_PORT_PULLUP)) begin
      portPullup <= pwdata[PINS-1:0];
    end
  end

  // Protected by default so a debugger poking registers leaves flags alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      breakClearEnable <= RST_BREAK_CLEAR;
    end else if (writeCycle && write_hit(paddr, OFS_BREAK_CONTROL)) begin
      breakClearEnable <= pwdata[BIT_BREAK_CLEAR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async(padIn),
    .synced(pinLevel)
  );

  port_a_pads #(
    .WIDTH(PINS)
  ) u_pads (
    .irqEnable(pinEnable),
    .direction(portDirection),
    .pullupEnable(portPullup),
    .dataOut(padOut),
    .pinLevel(pinLevel),
    .padOe(padOe),
    .padPullup(padPullup),
    .readValue(portRead)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clearing permission and acknowledge

  // A clear done during break stays done; the flags hold no break memory
  assign clearAllowed = !breakState || breakClearEnable;
  assign ackEvent = (vectorFetch || ackWrite) && clearAllowed;
  // The wakeup source ignores vector fetches
  assign awuClear = ackWrite && clearAllowed;

  ////////////////////////////////////////////////////////////////////////////
  // Auto wakeup source

  // Wakeup behaves as a seventh input that sits low while requested
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awuLatch <= 1'b0;
    end else if (awuWake) begin
      awuLatch <= 1'b1;
    end else if (awuClear) begin
      awuLatch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined input and edge detection

  // Disabled inputs count as high so they never hide or cause a fall
  assign allHigh = &(pinLevel | ~pinEnable) && !(awuEnable && awuLatch);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevAllHigh <= 1'b1;
    end else begin
      prevAllHigh <= allHigh;
    end
  end

  // A fall while another input is already low leaves allHigh low: no edge
  assign fallSeen = prevAllHigh && !allHigh;

  ////////////////////////////////////////////////////////////////////////////
  // Level-mode acknowledge tracking

  // Remembers an ack given while inputs are still low, so order is free
  always_comb begin
    next_levelState = levelState;
    unique case (levelState)
      LVL_IDLE: begin
        if (sensitivity && !allHigh) begin
          next_levelState = LVL_HELD;
        end
      end
      LVL_HELD: begin
        if (!sensitivity || allHigh) begin
          next_levelState = LVL_IDLE;
        end else if (ackEvent) begin
          next_levelState = LVL_ACKED;
        end
      end
      LVL_ACKED: begin
        if (!sensitivity || allHigh) begin
          next_levelState = LVL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      levelState <= LVL_IDLE;
    end else begin
      levelState <= next_levelState;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request latch

  // Level mode keeps setting the latch while any input is low and no ack is held
  assign latchSet = fallSeen ||
                    (sensitivity && !allHigh && levelState != LVL_ACKED);
  // Edge mode: ack clears at once. Level mode: ack plus release, any order
  assign latchClear = (ackEvent && (!sensitivity || allHigh)) ||
                      (levelState == LVL_ACKED && allHigh && clearAllowed);

  // Set wins over clear so an edge in the ack cycle is not lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      requestLatch <= 1'b0;
    end else if (latchSet) begin
      requestLatch <= 1'b1;
    end else if (latchClear) begin
      requestLatch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU side

  assign irqRequest = requestLatch && !irqMask;

  // Constant source loaded on every edge, so reset needs no branch
  always_ff @(posedge clk) begin
    irqVectorHi <= VECTOR_HI_ADDR;
    irqVectorLo <= VECTOR_LO_ADDR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      OFS_STATUS_CONTROL: begin
        next_prdata[BIT_SENSITIVITY] = sensitivity;
        next_prdata[BIT_MASK] = irqMask;
        next_prdata[BIT_ACK] = 1'b0;
        next_prdata[BIT_PENDING] = requestLatch;
      end
      OFS_ENABLE: begin
        next_prdata[PINS-1:0] = pinEnable;
        next_prdata[BIT_AWU_ENABLE] = awuEnable;
      end
      OFS_PORT_DATA: begin
        next_prdata[PINS-1:0] = portRead;
      end
      OFS_PORT_DIRECTION: begin
        next_prdata[PINS-1:0] = portDirection;
      end
      OFS_PORT_PULLUP: begin
        next_prdata[PINS-1:0] = portPullup;
      end
      OFS_BREAK_CONTROL: begin
        next_prdata[BIT_BREAK_CLEAR] = breakClearEnable;
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // Captured in setup so the access cycle shows stable data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupRead) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule // pin_irq_unit

`default_nettype wire

// ==== test/pin_irq_unit_chk.sv ====
// Purpose: Port checks for the pin interrupt unit
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module pin_irq_unit_chk
  import pin_irq_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PINS-1:0] padIn,
  input wire logic [PINS-1:0] padOut,
  input wire logic [PINS-1:0] padOe,
  input wire logic [PINS-1:0] padPullup,
  input wire logic vectorFetch,
  input wire logic breakState,
  input wire logic awuWake,
  input wire logic irqRequest,
  input wire logic [15:0] irqVectorHi,
  input wire logic [15:0] irqVectorLo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rdSt = psel && !penable && !pwrite && paddr == OFS_STATUS_CONTROL;
  wire wrSt = psel && penable && pwrite && pstrb[0] && paddr == OFS_STATUS_CONTROL;
  //////////////////////////////////////////////////
  property p_reset;
    $rose(rst_n) |-> !irqRequest && padOe == '0 && padPullup == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("state left after reset");
  property p_vector;
    $past(rst_n) |-> irqVectorHi == VECTOR_HI_ADDR && irqVectorLo == VECTOR_LO_ADDR;
  endproperty
  a_vector: assert property (p_vector) else $error("vector location wrong");
  property p_drive;
    (padOe & padPullup) == '0;
  endproperty
  a_drive: assert property (p_drive) else $error("pullup on a driven pin");
  property p_ackzero;
    rdSt |=> !prdata[BIT_ACK] && prdata[31:8] == '0 && !pslverr;
  endproperty
  a_ackzero: assert property (p_ackzero) else $error("ack bit read back");
  property p_mask;
    wrSt && pwdata[BIT_MASK] |=> !irqRequest;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request reached cpu");
  property p_pending;
    rdSt && irqRequest |=> prdata[BIT_PENDING] && !prdata[BIT_MASK];
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag missing");
  // Edge mode only; level mode may hold the request on purpose
  property p_ackclr;
    wrSt && pwdata[BIT_ACK] && !pwdata[BIT_SENSITIVITY] && !pwdata[BIT_MASK] && !breakState
      |=> ##1 !irqRequest;
  endproperty
  a_ackclr: assert property (p_ackclr) else $error("ack did not clear");
  property p_sync;
    (!psel && !awuWake && $stable(padIn)) [*4] |=> !$rose(irqRequest);
  endproperty
  a_sync: assert property (p_sync) else $error("request without a pin change");
endmodule // pin_irq_unit_chk
bind pin_irq_unit pin_irq_unit_chk #(.PINS(PINS)) i_chk (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .padIn, .padOut, .padOe,
  .padPullup, .vectorFetch, .breakState, .awuWake, .irqRequest, .irqVectorHi, .irqVectorLo);
`default_nettype wire

// ==== test/key_switches.sv ====
// Purpose: Switch model on the port pins
// Assumes: A pressed switch pulls its pin low
// Notes: An undriven pin without pullup wanders every cycle
`timescale 1ns/1ps
`default_nettype none
module key_switches
  import pin_irq_pkg::*;
(
  input wire logic clk,
  input wire logic [PIN_COUNT-1:0] pressed,
  input wire logic [PIN_COUNT-1:0] padOut,
  input wire logic [PIN_COUNT-1:0] padOe,
  input wire logic [PIN_COUNT-1:0] padPullup,
  output logic [PIN_COUNT-1:0] padIn
);
  logic [PIN_COUNT-1:0] drift = 6'h15;
  // Floating pins toggle so a stale level never passes for a pullup
  always @(posedge clk) drift <= ~drift;
  assign padIn = (padOe & padOut) | (~padOe & ~pressed & (padPullup | drift));
endmodule // key_switches
`default_nettype wire

// ==== test/pin_irq_unit_tb.sv ====
// Purpose: Self-checking bench for the pin interrupt unit
// Assumes: Zero-wait APB, pins seen 2 edges after change, request on the 3rd
// Notes: mPend, mMask and mMode model the expected state
`timescale 1ns/1ps
`default_nettype none
module pin_irq_unit_tb
  import pin_irq_pkg::*;
();
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic vectorFetch = 0, breakState = 0, awuWake = 0, pready, pslverr, irqRequest;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [5:0] padIn, padOut, padOe, padPullup, pressed = 6'h00;
  logic [15:0] irqVectorHi, irqVectorLo;
  logic mPend = 0, mMask = 0, mMode = 0;
  int fails = 0, totalChecks = 0, cyc = 0, seed = 80683, p, q;
  initial forever #20 clk = ~clk;
  pin_irq_unit #(.PINS(6)) i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .padIn, .padOut, .padOe, .padPullup, .vectorFetch,
    .breakState, .awuWake, .irqRequest, .irqVectorHi, .irqVectorLo);
  key_switches i_keys (.clk, .pressed, .padOut, .padOe, .padPullup, .padIn);
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic look;
    apb(1'b0, OFS_STATUS_CONTROL, 32'h0);
    chk(rd, {28'h0, mPend, 1'b0, mMask, mMode});
    chk(32'(irqRequest), 32'(mPend & ~mMask));
  endtask
  // Four edges covers synchroniser plus latch
  task automatic press(input logic [5:0] m);
    pressed <= m;
    repeat (4) @(posedge clk);
  endtask
  task automatic fetch;
    vectorFetch <= 1'b1;
    @(posedge clk) vectorFetch <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test;
    end
  end
  //////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      if (i != 2) begin
        apb(1'b0, 8'(i * 4), 32'h0);
        chk(rd, 32'h0);
      end
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
    // A write without byte lane 0 must leave the mask alone
    pstrb <= 4'he;
    wr(8'h00, 32'h2);
    pstrb <= 4'hf;
    look();
    // Safe start: mask, enable, ack, unmask
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h3f);
    wr(8'h00, 32'h6);
    wr(8'h00, 32'h0);
    look();
    chk(32'(padPullup), 32'h3f);
    for (int n = 0; n < 3; n++) begin
      p = $unsigned($random(seed)) % 6;
      q = (p + 1) % 6;
      press(6'(1 << p));
      mPend = 1'b1;
      look();
      wr(8'h00, 32'h4);
      mPend = 1'b0;
      look();
      press(6'((1 << p) | (1 << q)));
      look();
      press(6'h00);
      press(6'(1 << q));
      mPend = 1'b1;
      look();
      fetch();
      mPend = 1'b0;
      look();
      press(6'h00);
    end
    wr(8'h00, 32'h2);
    mMask = 1'b1;
    press(6'h01);
    mPend = 1'b1;
    look();
    wr(8'h00, 32'h6);
    mPend = 1'b0;
    look();
    press(6'h00);
    wr(8'h00, 32'h1);
    {mMask, mMode} = 2'b01;
    press(6'h04);
    mPend = 1'b1;
    fetch();
    look();
    press(6'h00);
    mPend = 1'b0;
    look();
    press(6'h04);
    press(6'h00);
    mPend = 1'b1;
    look();
    wr(8'h00, 32'h5);
    mPend = 1'b0;
    look();
    wr(8'h04, 32'h40);
    awuWake <= 1'b1;
    @(posedge clk) awuWake <= 1'b0;
    press(6'h00);
    mPend = 1'b1;
    fetch();
    look();
    wr(8'h00, 32'h5);
    mPend = 1'b0;
    look();
    wr(8'h04, 32'h3f);
    wr(8'h00, 32'h0);
    mMode = 1'b0;
    press(6'h02);
    mPend = 1'b1;
    breakState <= 1'b1;
    wr(8'h00, 32'h4);
    fetch();
    look();
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h4);
    breakState <= 1'b0;
    mPend = 1'b0;
    press(6'h00);
    look();
    wr(8'h14, 32'h0);
    wr(8'h0c, 32'h3f);
    chk(32'(padOe), 32'h0);
    wr(8'h04, 32'h0);
    chk(32'(padOe), 32'h3f);
    // Pins driven high before enabling must give no false fall
    wr(8'h08, 32'h3f);
    chk(32'(padOut), 32'h3f);
    wr(8'h04, 32'h3f);
    look();
    wr(8'h08, 32'h2a);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2a);
    chk(32'(padOut), 32'h2a);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h3f);
    press(6'h05);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h3a);
    wr(8'h04, 32'h3f);
    wr(8'h00, 32'h1);
    press(6'h01);
    {mPend, mMode} = 2'b11;
    look();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    {mPend, mMode} = 2'b00;
    look();
    chk(32'(padPullup), 32'h0);
    finish_test;
  end
endmodule // pin_irq_unit_tb
`default_nettype wire
